/* File: hw/bandgap_trim_registers.sv */
// Wishbone classic slave holding the four bandgap trim registers.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module bandgap_trim_registers
   import bandgap_trim_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_sel_i,
   output logic [7:0] wb_dat_o,
   output logic wb_ack_o,
   output trim_fields_s trim_o
);
   decode_s dec;
   logic ack_q;
   logic [7:0] rdata_q;
   logic req;
   logic [7:0] regs [NUM_REGS];
   logic [NUM_REGS-1:0] wr_en;
   localparam logic [7:0] MASKS [NUM_REGS] =
      '{MASK_TWO_FIELDS, MASK_TWO_FIELDS, MASK_FULL, MASK_SLOPE};
   localparam int HI_MSB = 5;
   localparam int HI_LSB = 3;
   localparam int LO_MSB = 2;
   localparam int LO_LSB = 0;
   localparam int UP_BIT = 7;
   localparam int DOWN_BIT = 6;

   // The decoder hands over a two-bit index, so the bank cannot grow past four registers.
   generate
      if (NUM_REGS != 4)
      begin : g_bad_count
         $error("trim bank needs exactly four registers");
      end
   endgenerate

   trim_addr_decode u_decode
   (
      .addr_i(wb_adr_i),
      .dec_o(dec)
   );

   // A one-cycle ack keeps the slave simple; every access, mapped or not, is answered.
   assign req = wb_cyc_i && wb_stb_i && !ack_q;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++)
      begin : g_reg
         assign wr_en[g] = req && wb_we_i && wb_sel_i && dec.hit && dec.index == 2'(g);
         trim_byte_reg #(.WMASK(MASKS[g])) u_reg
         (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .we_i(wr_en[g]),
            .wdata_i(wb_dat_i),
            .q_o(regs[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_q <= TRIM_RESET;
      end
      else if (req && !wb_we_i)
      begin
         rdata_q <= dec.hit ? regs[dec.index] : TRIM_RESET; // R08
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   assign trim_o.second_current_trim = regs[0][HI_MSB:HI_LSB]; // R02
   assign trim_o.first_current_trim = regs[0][LO_MSB:LO_LSB]; // R02
   assign trim_o.second_bias_trim = regs[1][HI_MSB:HI_LSB]; // R03
   assign trim_o.first_bias_trim = regs[1][LO_MSB:LO_LSB]; // R03
   assign trim_o.up_adjust_bit = regs[2][UP_BIT]; // R04
   assign trim_o.down_adjust_bit = regs[2][DOWN_BIT]; // R04
   assign trim_o.second_tempco_trim = regs[2][HI_MSB:HI_LSB]; // R04
   assign trim_o.first_tempco_trim = regs[2][LO_MSB:LO_LSB]; // R04
   assign trim_o.slope_trim = regs[3][LO_MSB:LO_LSB]; // R05

   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle"); // R01
   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not answered"); // R01
   a_bg0_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      regs[0][7:6] == 2'b00) else $error("current trim top bits set"); // R02
   a_bg0_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      regs[1][7:6] == 2'b00) else $error("bias trim top bits set"); // R03
   a_bg1_write_full: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en[2] |=> regs[2] == $past(wb_dat_i)) else $error("tempco write lost"); // R04
   a_slope_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      regs[3][7:3] == 5'h00) else $error("slope upper bits set"); // R05
   a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en[0] |=> regs[0] == ($past(wb_dat_i) & MASK_TWO_FIELDS)) else $error("mask wrong"); // R08
   a_hold_value: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_en[1] |=> $stable(regs[1])) else $error("register changed without write"); // R08
   a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && dec.hit) |=> wb_dat_o == regs[$past(dec.index)])
      else $error("read data mismatch"); // R08
   a_reset_zero: assert property (@(posedge clk_i)
      $past(rst_i) |-> regs[2] == TRIM_RESET) else $error("reset value not zero"); // R04
   a_reset_all_zero: assert property (@(posedge clk_i)
      $past(rst_i) |-> (regs[0] | regs[1] | regs[3]) == TRIM_RESET)
      else $error("reset value of a trim register not zero"); // R02

   c_write_blocking: cover property (@(posedge clk_i) wr_en[0] && wb_adr_i[8] == 1'b0);
   c_write_nonblock: cover property (@(posedge clk_i) wr_en[3] && wb_adr_i[8] == 1'b1);
   c_read_hit: cover property (@(posedge clk_i) req && !wb_we_i && dec.hit);
   c_unmapped: cover property (@(posedge clk_i) req && !dec.hit);
endmodule

/* File: hw/bandgap_trim_pkg.sv */
// Constants, field layouts and carrier types for the bandgap trim register bank.
// Functional notes
// R01: Each trim register is found at its offset above the blocking base or above the non-blocking base.
// R02: The register at offset e0 holds the second current trim in bits 5-3 and the first in bits 2-0, top two bits zero, reset zero.
// R03: The register at offset e1 holds the second bias trim in bits 5-3 and the first in bits 2-0, top two bits zero, reset zero.
// R04: The register at offset e2 holds up adjust at bit 7, down adjust at bit 6 and two tempco trims in 5-3 and 2-0, reset zero.
// R05: The register at offset e3 holds the slope trim in bits 2-0, bits 7-3 read zero, reset zero.
// R06: Software copies the factory trim values from the information flash area into every trim register.
// R07: Software repeats that copy after every power-up because the registers reset to zero.
// R08: Writes to always-zero bit positions are ignored and stored fields read back unchanged.
package bandgap_trim_pkg;
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] BLOCKING_BASE = 16'h0200;
   localparam logic [ADDR_W-1:0] NONBLOCKING_BASE = 16'h0300;
   localparam logic [7:0] BANDGAP0_CURRENT_TRIM_HIGH_OFF = 8'he0;
   localparam logic [7:0] BANDGAP0_BIAS_TRIM_LOW_OFF = 8'he1;
   localparam logic [7:0] BANDGAP1_TEMPCO_TRIM_HIGH_OFF = 8'he2;
   localparam logic [7:0] BANDGAP1_SLOPE_TRIM_LOW_OFF = 8'he3;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam logic [7:0] MASK_TWO_FIELDS = 8'h3f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_SLOPE = 8'h07;
   localparam int NUM_REGS = 4;

   typedef struct packed {
      logic [2:0] second_current_trim;
      logic [2:0] first_current_trim;
      logic [2:0] second_bias_trim;
      logic [2:0] first_bias_trim;
      logic up_adjust_bit;
      logic down_adjust_bit;
      logic [2:0] second_tempco_trim;
      logic [2:0] first_tempco_trim;
      logic [2:0] slope_trim;
   } trim_fields_s;

   typedef struct packed {
      logic hit;
      logic [1:0] index;
   } decode_s;
endpackage

/* File: hw/trim_addr_decode.sv */
// Byte-address decoder for the trim bank in both access windows.
`timescale 1ns/1ps
module trim_addr_decode
   import bandgap_trim_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr_i,
   output decode_s dec_o
);
   function automatic decode_s decode(input logic [ADDR_W-1:0] a);
      decode_s d;
      logic [ADDR_W-1:0] off;
      d = '0;
      off = '0;
      if (a[ADDR_W-1:8] == BLOCKING_BASE[ADDR_W-1:8]) // R01
      begin
         off = a - BLOCKING_BASE;
      end
      else if (a[ADDR_W-1:8] == NONBLOCKING_BASE[ADDR_W-1:8]) // R01
      begin
         off = a - NONBLOCKING_BASE;
      end
      else
      begin
         off = {ADDR_W{1'b1}};
      end
      if (off[7:2] == BANDGAP0_CURRENT_TRIM_HIGH_OFF[7:2] && off[ADDR_W-1:8] == '0)
      begin
         d.hit = 1'b1;
         d.index = 2'(off[1:0] - BANDGAP0_CURRENT_TRIM_HIGH_OFF[1:0]);
      end
      return d;
   endfunction

   assign dec_o = decode(addr_i);
endmodule

/* File: hw/trim_byte_reg.sv */
// One eight-bit trim register with a mask of writable bits.
`timescale 1ns/1ps
module trim_byte_reg
   import bandgap_trim_pkg::*;
#(
   parameter logic [7:0] WMASK = MASK_FULL
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] q_o
);
   logic [7:0] value_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         value_q <= TRIM_RESET;
      end
      else if (we_i)
      begin
         value_q <= wdata_i & WMASK; // R08
      end
   end

   assign q_o = value_q;
endmodule

/* File: test/mcu_model.sv */
// Microcontroller model that copies trim values from its flash over Wishbone.
`timescale 1ns/1ps
module mcu_model
   import bandgap_trim_pkg::*;
(
   input wire logic clk_i,
   input wire logic wb_ack_i,
   input wire logic [7:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [ADDR_W-1:0] wb_adr_o,
   output logic [7:0] wb_dat_o,
   output logic wb_sel_o
);
   logic [7:0] flash_q [NUM_REGS];
   initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_dat_o, wb_sel_o} = '0;
   task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic s, output logic [7:0] r);
      @(posedge clk_i);
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_dat_o, wb_sel_o} <= {2'b11, w, a, d, s};
      do @(posedge clk_i); while (wb_ack_i !== 1'b1);
      r = wb_dat_i;
      {wb_cyc_o, wb_stb_o} <= 2'b00;
      // Released data shows its inverse so a stale value is never mistaken for a live one.
      wb_dat_o <= ~d;
   endtask
   task automatic copy_trims(input logic [ADDR_W-1:0] base);
      logic [7:0] r;
      for (int i = 0; i < NUM_REGS; i++)
         access(1'b1, base + 16'he0 + 16'(i), flash_q[i], 1'b1, r);
   endtask
endmodule

/* File: test/bandgap_trim_registers_tb.sv */
// Random and corner tests of the trim bank.
`timescale 1ns/1ps
module bandgap_trim_registers_tb
   import bandgap_trim_pkg::*;
();
   logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, sel, ack;
   logic [ADDR_W-1:0] adr;
   logic [7:0] wd, rd, r, sh [NUM_REGS];
   logic [ADDR_W-1:0] bad [3] = '{16'h02e4, 16'h01e0, 16'h03df};
   trim_fields_s trim;
   int err_total = 0, tests_run = 0;
   always #2.5 clk_i = ~clk_i;
   bandgap_trim_registers u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd),
      .wb_ack_o(ack), .trim_o(trim));
   mcu_model u_mcu (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rd), .wb_cyc_o(cyc),
      .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_dat_o(wd), .wb_sel_o(sel));
   function automatic logic [7:0] msk(int i);
      return i == 3 ? MASK_SLOPE : i == 2 ? MASK_FULL : MASK_TWO_FIELDS;
   endfunction
   task automatic chk(input logic [22:0] got, input logic [22:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_all(input logic [ADDR_W-1:0] base);
      for (int i = 0; i < NUM_REGS; i++)
      begin
         u_mcu.access(1'b0, base + 16'he0 + 16'(i), 8'h00, 1'b1, r);
         chk(23'(r), 23'(sh[i]));
      end
      chk(trim, {sh[0][5:0], sh[1][5:0], sh[2], sh[3][2:0]});
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      int i;
      logic s;
      logic [7:0] d;
      void'($urandom(73042));
      sh = '{default: 8'h00};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_all(BLOCKING_BASE);
      rd_all(NONBLOCKING_BASE);
      $display("reset values done");
      for (int k = 0; k < 2; k++)
      begin
         foreach (sh[j]) u_mcu.flash_q[j] = 8'($urandom);
         u_mcu.copy_trims(k ? BLOCKING_BASE : NONBLOCKING_BASE);
         foreach (sh[j]) sh[j] = u_mcu.flash_q[j] & msk(j);
         rd_all(k ? NONBLOCKING_BASE : BLOCKING_BASE);
      end
      $display("trim copy done");
      for (int k = 0; k < 24; k++)
      begin
         i = $urandom % 4;
         s = k % 5 != 0;
         d = k < 4 ? 8'hff : 8'($urandom);
         u_mcu.access(1'b1, (k[0] ? NONBLOCKING_BASE : BLOCKING_BASE) + 16'he0 + 16'(i), d, s, r);
         if (s) sh[i] = d & msk(i);
         rd_all(BLOCKING_BASE);
      end
      $display("random writes done");
      foreach (bad[j])
      begin
         u_mcu.access(1'b1, bad[j], 8'hff, 1'b1, r);
         u_mcu.access(1'b0, bad[j], 8'h00, 1'b1, r);
         chk(23'(r), 23'h0);
      end
      rd_all(NONBLOCKING_BASE);
      $display("unmapped done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      sh = '{default: 8'h00};
      rd_all(BLOCKING_BASE);
      u_mcu.copy_trims(BLOCKING_BASE);
      foreach (sh[j]) sh[j] = u_mcu.flash_q[j] & msk(j);
      rd_all(NONBLOCKING_BASE);
      $display("second reset done");
      close_out();
   end
   // The span is far above the few hundred cycles that the tests need.
   initial
   begin
      #100000;
      err_total++;
      close_out();
   end
endmodule
